// file: bench/master_serial_config_loader_sva.sv
`timescale 1ns/10ps
module master_serial_config_loader_sva
	import loader_pkg::*;
#(
	parameter int IMAGE_BITS = IMAGE_BITS_MIN,
	parameter int RATE_LIMIT = RATE_LIMIT_STD
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic reload_request_n_i,
	input wire logic config_clock_out_o,
	input wire logic serial_out_o,
	input wire od_pad_s init_pad_o,
	input wire od_pad_s done_pad_o,
	input wire cfg_write_s cfg_write_o,
	input wire logic clearing_o,
	input wire logic crc_error_o,
	input wire logic user_io_o
);
	localparam int CEIL_HALF = (HALF_LOWEST + RATE_LIMIT - 1) / RATE_LIMIT;
	localparam int MIN_HALF = (CEIL_HALF < HALF_MIN) ? HALF_MIN : CEIL_HALF;
	logic [7:0] hi, next_hi;
	logic [4:0] lo, next_lo;
	// Lengths of the clock-high and reload-low runs
	always_comb begin
		next_hi = config_clock_out_o ? hi + 8'h1 : 8'h0;
		next_lo = reload_request_n_i ? 5'h0 : (lo == 5'h1F) ? lo : lo + 5'h1;
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hi <= 8'h0;
			lo <= 5'h0;
		end else begin
			hi <= next_hi;
			lo <= next_lo;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	a_clear_len: assert property ($fell(clearing_o) |-> $past(clearing_o, 38))
		else $error("clearing too short");
	a_clk_clear: assert property (clearing_o && $past(clearing_o) |->
		!config_clock_out_o && !done_pad_o.oe_n) else $error("clock or done while clearing");
	a_crc_init: assert property ($rose(crc_error_o) |-> ##[0:1] !init_pad_o.oe_n)
		else $error("init not pulled on check error");
	a_clk_slow: assert property (config_clock_out_o |-> hi < HALF_LOWEST)
		else $error("clock high too long");
	a_clk_fast: assert property ($fell(config_clock_out_o) && !clearing_o &&
		!user_io_o && !crc_error_o |-> hi >= MIN_HALF) else $error("clock above cap");
	a_write_rise: assert property (cfg_write_o.valid |->
		$past(config_clock_out_o) && !$past(config_clock_out_o, 2)) else $error("write off rise");
	a_dout_idle: assert property (!done_pad_o.oe_n && !$past(done_pad_o.oe_n) |->
		serial_out_o) else $error("data out not driven high");
	a_fwd_fall: assert property ($changed(serial_out_o) && done_pad_o.oe_n |->
		!config_clock_out_o) else $error("forward off falling clock");
	a_reload_hold: assert property (lo == 5'h10 |-> clearing_o &&
		!done_pad_o.oe_n && !init_pad_o.oe_n) else $error("long reload ignored");
endmodule

// file: bench/master_serial_config_loader_test.sv
`timescale 1ns/10ps
module master_serial_config_loader_test;
	import loader_pkg::*;
	localparam int IB = 32;
	localparam int RL = 3;
	logic clk_i = 1'b0, resetn_i = 1'b0, reload_n = 1'b1, pulse_req = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [63:0] stream = 64'h0;
	logic [31:0] seed = 32'h4ED7;
	logic [6:0] chain;
	logic [7:0] chain_got, rate_o;
	logic [IB-1:0] got;
	logic data, init_hold_n, pulse_n, init_w, done_w, cfg_clk, dout, user, crc_e, mode_e, clr;
	od_pad_s init_pad, done_pad;
	cfg_write_s wr;
	int fails = 0, num_checks = 0, nwr = 0, pc = 0, per = 0, sc = 0, cyc = 0;
	// Clock and the pulled-up open-drain wires
	always #25 clk_i = ~clk_i;
	assign init_w = init_pad.oe_n & init_hold_n;
	assign done_w = done_pad.oe_n & (sc == 8);
	master_serial_config_loader #(.IMAGE_BITS(IB), .RATE_LIMIT(RL)) u_dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .prom_serial_out_i(data), .mode_i(mode),
		.init_in_i(init_w), .done_in_i(done_w), .reload_request_n_i(reload_n & pulse_n),
		.config_clock_out_o(cfg_clk), .serial_out_o(dout), .init_pad_o(init_pad),
		.done_pad_o(done_pad), .cfg_write_o(wr), .clearing_o(clr), .crc_error_o(crc_e),
		.mode_error_o(mode_e), .user_io_o(user), .clock_rate_option_o(rate_o));
	prom_model u_prom (.cfg_clk_i(cfg_clk), .oe_reset_i(init_w), .ce_n_i(done_w),
		.pulse_req_i(pulse_req), .image_i(stream), .data_o(data), .init_hold_n_o(init_hold_n),
		.prom_reload_pulse_o(pulse_n));
	// Chain slave holds done low until it has a zero mark and seven bits
	always @(posedge cfg_clk or negedge done_pad.oe_n) begin
		if (!done_pad.oe_n) begin
			sc <= 0;
		end else if (sc < 8 && (sc > 0 || !dout)) begin
			chain_got <= {chain_got[6:0], dout};
			sc <= sc + 1;
		end
	end
	// Image writes, their spacing, run limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		pc <= wr.valid ? 1 : pc + 1;
		if (wr.valid === 1'b1) begin
			got <= {got[IB-2:0], wr.data};
			nwr <= nwr + 1;
			per <= pc;
		end
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] crc(input logic [39:0] d);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 39; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0);
		end
		return c;
	endfunction
	// Half period in clocks; the cap keeps it above the floor
	function automatic int half(input int r);
		int m;
		m = (r > RL) ? RL : r;
		return (r == 0) ? HALF_LOWEST : (HALF_LOWEST + m - 1) / m;
	endfunction
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task results;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Restart through the memory pulse, then in master mode one load with a glitch on reload
	task automatic load(input logic bad, input logic [2:0] md, input logic [7:0] r);
		logic [IB-1:0] img;
		logic [15:0] c;
		int sp;
		@(posedge clk_i);
		img = rnd();
		chain = 7'(rnd());
		sp = 2 + rnd() % 7;
		c = crc({r, img}) ^ {15'h0, bad};
		stream <= {r, img, c, 1'b0, chain};
		mode <= md;
		pulse_req <= 1'b1;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		chk("restart pads", 3'h4, {clr, init_pad.oe_n, done_pad.oe_n});
		@(posedge clk_i);
		pulse_req <= 1'b0;
		nwr = 0;
		if (md != MODE_MASTER) begin
			repeat (80) @(posedge clk_i);
			chk("mode stop", 64'h2_0000_0000, {mode_e, cfg_clk, nwr});
		end else begin
			wait (nwr == 4);
			@(posedge clk_i);
			reload_n <= 1'b0;
			repeat (sp) @(posedge clk_i);
			reload_n <= 1'b1;
			if (bad) begin
				wait (crc_e === 1'b1);
				@(negedge clk_i);
				chk("fail pads", 2'h0, {init_pad.oe_n, done_pad.oe_n});
			end else begin
				wait (user === 1'b1);
				@(posedge clk_i);
				@(negedge clk_i);
				chk("rate", r, rate_o);
				chk("period", 2 * half(r), per);
				chk("chain", {1'b0, chain}, chain_got);
				chk("done", 3'h6, {done_pad.oe_n, init_pad.oe_n, cfg_clk});
			end
			chk("image", img, got);
			chk("writes", IB, nwr);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		wait (init_pad.oe_n === 1'b1);
		repeat (10) @(negedge clk_i);
		chk("early clock", 2'h0, {init_w, cfg_clk});
		load(1'b0, MODE_MASTER, 8'h0);
		load(1'b1, MODE_MASTER, 8'h19);
		load(1'b0, MODE_SLAVE, 8'h3);
		repeat (4) load(1'b0, MODE_MASTER, 8'(rnd() % 31));
		results();
	end
endmodule
bind master_serial_config_loader master_serial_config_loader_sva #(
	.IMAGE_BITS(IMAGE_BITS), .RATE_LIMIT(RATE_LIMIT)) u_sva (.clk_i, .resetn_i,
	.reload_request_n_i, .config_clock_out_o, .serial_out_o, .init_pad_o, .done_pad_o,
	.cfg_write_o, .clearing_o, .crc_error_o, .user_io_o);

// file: bench/prom_model.sv
`timescale 1ns/10ps
// Serial configuration memory with power-on hold and reload pulse output
module prom_model #(
	parameter int LEN = 64,
	parameter int POR_NS = 3000
) (
	input wire logic cfg_clk_i,
	input wire logic oe_reset_i,
	input wire logic ce_n_i,
	input wire logic pulse_req_i,
	input wire logic [LEN-1:0] image_i,
	output logic data_o,
	output logic init_hold_n_o,
	output logic prom_reload_pulse_o
);
	int addr = 0;
	logic last = 1'b0;
	// Init wire held low until own power-on reset ends
	initial begin
		init_hold_n_o = 1'b0;
		#POR_NS init_hold_n_o = 1'b1;
	end
	// Reload pulse output, wired onto the reload input
	assign prom_reload_pulse_o = ~pulse_req_i;
	// Address steps at falling clock while enabled, cleared by init low
	always @(negedge cfg_clk_i or negedge oe_reset_i) begin
		if (!oe_reset_i) begin
			addr <= 0;
		end else if (!ce_n_i) begin
			addr <= addr + 1;
		end
	end
	// Released line shows the inverse of the last bit
	always @(negedge cfg_clk_i) begin
		last <= data_o;
	end
	// Stream bits, MSB first; holds all chain images
	always_comb begin
		if (oe_reset_i && !ce_n_i && addr < LEN) begin
			data_o = image_i[LEN-1-addr];
		end else begin
			data_o = ~last;
		end
	end
endmodule

// file: rtl/config_clock_out_divider.sv
`timescale 1ns/10ps
module config_clk_divider #(
	parameter int HALF_W = 4
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic [HALF_W-1:0] half_i,
	output logic cfg_clk_o,
	output logic rise_o,
	output logic fall_o
);

	logic [HALF_W-1:0] cnt;
	logic [HALF_W-1:0] next_cnt;
	logic next_cfg_clk;
	logic next_rise;
	logic next_fall;

	// Toggle the clock every half_i cycles while running, park low otherwise
	always_comb begin
		next_cnt = cnt;
		next_cfg_clk = cfg_clk_o;
		next_rise = 1'b0;
		next_fall = 1'b0;
		if (!run_i) begin
			next_cnt = '0;
			next_cfg_clk = 1'b0;
		end else if (cnt >= half_i - HALF_W'(1)) begin
			next_cnt = '0;
			next_cfg_clk = ~cfg_clk_o;
			next_rise = ~cfg_clk_o;
			next_fall = cfg_clk_o;
		end else begin
			next_cnt = cnt + HALF_W'(1);
		end
	end

	// Edge pulses line up with the cycle the new level appears
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= '0;
			cfg_clk_o <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			cfg_clk_o <= next_cfg_clk;
			rise_o <= next_rise;
			fall_o <= next_fall;
		end
	end

endmodule

// file: rtl/loader_pkg.sv
package loader_pkg;

	// Clocking of the loader
	localparam int CLK_MHZ = 20;
	localparam int CLK_PERIOD_NS = 50;

	// Restart pulse on the reload input
	localparam int RELOAD_MIN_NS = 500;
	localparam int RELOAD_MIN_CYCLES = (RELOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELOAD_CNT_W = 5;

	// Configuration memory clearing time
	localparam int CLEAR_NS = 2000;
	localparam int CLEAR_CYCLES = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CNT_W = 8;

	// Image sizes of the family, smallest and largest
	localparam int IMAGE_BITS_MIN = 581344;
	localparam int IMAGE_BITS_MAX = 5969696;
	localparam int BIT_CNT_W = 23;

	// Stream framing: rate option, image, check word
	localparam int RATE_BITS = 8;
	localparam int CRC_BITS = 16;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;

	// Clock rate limits, roughly in MHz
	localparam int RATE_LIMIT_STD = 25;
	localparam int RATE_LIMIT_1V8 = 12;
	localparam int RATE_LOWEST = 1;
	localparam int HALF_W = 4;
	localparam int HALF_MIN = 2;
	localparam int HALF_LOWEST = CLK_MHZ / (2 * RATE_LOWEST);

	// Mode select codes
	localparam logic [2:0] MODE_MASTER = 3'h0;
	localparam logic [2:0] MODE_SLAVE = 3'h7;

	// Synchroniser reset image: reload input idles high
	localparam logic [6:0] SYNC_RESET = 7'h40;

	typedef enum logic [2:0] {
		ST_CLEAR = 3'b000,
		ST_WAIT_INIT = 3'b001,
		ST_LOAD = 3'b010,
		ST_FORWARD = 3'b011,
		ST_USER = 3'b100,
		ST_CRC_FAIL = 3'b101,
		ST_MODE_FAIL = 3'b110,
		ST_HOLD = 3'b111
	} load_state_e;

	// Open-drain pad drive: level is always low, oe_n low pulls the wire
	typedef struct packed {
		logic level;
		logic oe_n;
	} od_pad_s;

	// One bit written into configuration memory
	typedef struct packed {
		logic valid;
		logic data;
	} cfg_write_s;

endpackage

// file: rtl/master_serial_config_loader.sv
`timescale 1ns/10ps
// Contract
// RULE1: Configuration bits arrive serially on the data input from the memory.
// RULE2: Loader makes the configuration clock itself; the rate option caps it.
// RULE3: Start at the lowest rate; speed up only when the stream asks.
// RULE4: Rate option never above the memory limit, 25 or 12.
// RULE5: Serial data output is driven during the whole load.
// RULE6: Chain master forwards later bits on serial output at falling clock.
// RULE7: Init pin low while clearing; released when clearing ends, modes sampled.
// RULE8: Check-word mismatch pulls the init pin low again.
// RULE9: Init pin resets the memory address, then enables its outputs.
// RULE10: Memory may hold init low until its own power-on reset ends.
// RULE11: Done pin low during load, released only after a good load.
// RULE12: Done low enables the memory; done high disables it.
// RULE13: Reload low 500 ns or more clears and restarts on release.
// RULE14: Reload stays high during load; start only while it is high.
// RULE15: The memory's reload pulse output may drive the reload input low.
// RULE16: Image length follows density; a chain memory holds all images.
// RULE17: Each bit is captured at a rising configuration clock edge.
// RULE18: Master mode when all mode pins low, sampled as init rises.
// RULE19: After done rises, configuration pins go back to user logic.
module master_serial_config_loader #(
	parameter int IMAGE_BITS = loader_pkg::IMAGE_BITS_MIN,
	parameter int RATE_LIMIT = loader_pkg::RATE_LIMIT_STD
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic prom_serial_out_i,
	input wire logic [2:0] mode_i,
	input wire logic init_in_i,
	input wire logic done_in_i,
	input wire logic reload_request_n_i,
	output logic config_clock_out_o,
	output logic serial_out_o,
	output loader_pkg::od_pad_s init_pad_o,
	output loader_pkg::od_pad_s done_pad_o,
	output loader_pkg::cfg_write_s cfg_write_o,
	output logic clearing_o,
	output logic crc_error_o,
	output logic mode_error_o,
	output logic user_io_o,
	output logic [7:0] clock_rate_option_o
);

	import loader_pkg::*;

	localparam int TOTAL_BITS = RATE_BITS + IMAGE_BITS + CRC_BITS; // RULE16
	localparam logic [BIT_CNT_W-1:0] LAST_RATE = BIT_CNT_W'(RATE_BITS - 1);
	localparam logic [BIT_CNT_W-1:0] LAST_IMAGE = BIT_CNT_W'(RATE_BITS + IMAGE_BITS - 1);
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(TOTAL_BITS - 1);
	localparam logic [RELOAD_CNT_W-1:0] RELOAD_LAST = RELOAD_CNT_W'(RELOAD_MIN_CYCLES - 1);
	localparam logic [CLEAR_CNT_W-1:0] CLEAR_LAST = CLEAR_CNT_W'(CLEAR_CYCLES - 1);
	localparam logic [7:0] RATE_CAP = 8'(RATE_LIMIT);

	// Pin synchronisers
	logic [6:0] sync_meta;
	logic [6:0] sync_q;
	logic din_s;
	logic [2:0] mode_s;
	logic init_s;
	logic done_s;
	logic reload_n_s;

	// Loader state
	load_state_e state;
	load_state_e next_state;
	logic [RELOAD_CNT_W-1:0] reload_cnt;
	logic [RELOAD_CNT_W-1:0] next_reload_cnt;
	logic [CLEAR_CNT_W-1:0] clear_cnt;
	logic [CLEAR_CNT_W-1:0] next_clear_cnt;
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [BIT_CNT_W-1:0] next_bit_cnt;
	logic [15:0] crc;
	logic [15:0] next_crc;
	logic [15:0] crc_rx;
	logic [15:0] next_crc_rx;
	logic [7:0] next_rate;
	logic [HALF_W-1:0] half;
	logic [HALF_W-1:0] next_half;
	logic run;
	logic next_run;
	logic last_bit;
	logic next_last_bit;
	logic next_serial_out;
	od_pad_s next_init_pad;
	od_pad_s next_done_pad;
	cfg_write_s next_cfg_write;
	logic next_clearing;
	logic next_crc_error;
	logic next_mode_error;
	logic next_user_io;

	// Divider outputs
	logic cfg_clk;
	logic cfg_rise;
	logic cfg_fall;

	// Half period in system cycles for a rate option, capped by the memory
	function automatic logic [HALF_W-1:0] half_for(input logic [7:0] r);
		int capped;
		int h;
		capped = (r > RATE_CAP) ? RATE_LIMIT : int'(r);
		h = (CLK_MHZ + 2 * capped - 1) / (2 * capped);
		if (h < HALF_MIN) begin
			h = HALF_MIN;
		end
		return HALF_W'(h);
	endfunction

	// One CRC step over a single stream bit
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		return {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_meta <= SYNC_RESET;
			sync_q <= SYNC_RESET;
		end else begin
			sync_meta <= {reload_request_n_i, done_in_i, init_in_i, mode_i, prom_serial_out_i};
			sync_q <= sync_meta;
		end
	end

	assign din_s = sync_q[0]; // RULE1
	assign mode_s = sync_q[3:1];
	assign init_s = sync_q[4];
	assign done_s = sync_q[5];
	assign reload_n_s = sync_q[6];

	// Configuration clock generator
	config_clk_divider #(
		.HALF_W(HALF_W)
	) u_clk_divider (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(run),
		.half_i(half),
		.cfg_clk_o(cfg_clk),
		.rise_o(cfg_rise),
		.fall_o(cfg_fall)
	);

	assign config_clock_out_o = cfg_clk; // RULE2

	// Next-state logic of the loader
	always_comb begin
		next_state = state;
		next_reload_cnt = reload_cnt;
		next_clear_cnt = clear_cnt;
		next_bit_cnt = bit_cnt;
		next_crc = crc;
		next_crc_rx = crc_rx;
		next_rate = clock_rate_option_o;
		next_half = half;
		next_run = run;
		next_last_bit = last_bit;
		next_serial_out = serial_out_o;
		next_init_pad = init_pad_o;
		next_done_pad = done_pad_o;
		next_cfg_write = '0;
		next_clearing = clearing_o;
		next_crc_error = crc_error_o;
		next_mode_error = mode_error_o;
		next_user_io = user_io_o;

		unique case (state)
			// Clear memory with init pulled low
			ST_CLEAR: begin
				next_init_pad.oe_n = 1'b0; // RULE7 RULE9
				next_clearing = 1'b1;
				next_clear_cnt = clear_cnt + CLEAR_CNT_W'(1);
				if (clear_cnt == CLEAR_LAST) begin
					next_init_pad.oe_n = 1'b1; // RULE7
					next_clearing = 1'b0;
					next_state = ST_WAIT_INIT;
				end
			end
			// Wait for the wired init to rise, then sample the mode pins
			ST_WAIT_INIT: begin
				if (init_s && reload_n_s) begin // RULE10 RULE14
					if (mode_s == MODE_MASTER) begin // RULE18
						next_state = ST_LOAD;
						next_bit_cnt = '0;
						next_crc = CRC_INIT;
						next_crc_rx = '0;
						next_rate = '0;
						next_half = HALF_W'(HALF_LOWEST); // RULE3
						next_run = 1'b1;
					end else begin
						next_mode_error = 1'b1;
						next_state = ST_MODE_FAIL;
					end
				end
			end
			// Shift in rate option, image and check word
			ST_LOAD: begin
				if (cfg_rise) begin // RULE17
					next_last_bit = din_s | (bit_cnt == LAST_BIT); // RULE6 idle, check word kept
					next_bit_cnt = bit_cnt + BIT_CNT_W'(1);
					if (bit_cnt <= LAST_IMAGE) begin
						next_crc = crc_step(crc, din_s);
					end else begin
						next_crc_rx = {crc_rx[14:0], din_s};
					end
					if (bit_cnt <= LAST_RATE) begin
						next_rate = {clock_rate_option_o[6:0], din_s};
					end else if (bit_cnt <= LAST_IMAGE) begin
						next_cfg_write.valid = 1'b1;
						next_cfg_write.data = din_s;
					end
					if (bit_cnt == LAST_RATE && next_rate != 8'h00) begin
						next_half = half_for(next_rate); // RULE3 RULE4
					end
					if (bit_cnt == LAST_BIT) begin
						if (next_crc_rx != crc) begin
							next_init_pad.oe_n = 1'b0; // RULE8
							next_crc_error = 1'b1;
							next_run = 1'b0;
							next_state = ST_CRC_FAIL;
						end else begin
							next_done_pad.oe_n = 1'b1; // RULE11 RULE12
							next_state = ST_FORWARD;
						end
					end
				end
			end
			// Pass later bits to the chain until the wired done rises
			ST_FORWARD: begin
				if (cfg_rise) begin // RULE17
					next_last_bit = din_s;
				end
				if (cfg_fall) begin
					next_serial_out = last_bit; // RULE6
				end
				if (done_s) begin
					next_run = 1'b0;
					next_user_io = 1'b1; // RULE19
					next_state = ST_USER;
				end
			end
			// Pins belong to user logic
			ST_USER: begin
				next_run = 1'b0;
			end
			// Failed load holds init low until a reload
			ST_CRC_FAIL: begin
				next_init_pad.oe_n = 1'b0; // RULE8
			end
			// Not master mode: stay idle until a reload
			ST_MODE_FAIL: begin
				next_run = 1'b0;
			end
			// Reload held low: memory cleared, pins reset
			ST_HOLD: begin
				if (reload_n_s) begin // RULE13 RULE14
					next_clear_cnt = '0;
					next_state = ST_CLEAR;
				end
			end
		endcase

		// Long enough low pulse on reload overrides the state, clock, pads, flags and serial output
		if (!reload_n_s) begin
			if (reload_cnt != RELOAD_LAST) begin
				next_reload_cnt = reload_cnt + RELOAD_CNT_W'(1);
			end else begin
				next_state = ST_HOLD; // RULE13 RULE15
				next_run = 1'b0;
				next_half = HALF_W'(HALF_LOWEST);
				next_init_pad.oe_n = 1'b0;
				next_done_pad.oe_n = 1'b0;
				next_clearing = 1'b1;
				next_crc_error = 1'b0;
				next_mode_error = 1'b0;
				next_user_io = 1'b0;
				next_serial_out = 1'b1;
			end
		end else begin
			next_reload_cnt = '0;
		end
	end

	// Loader registers; done held low from reset until a good load
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_CLEAR;
			reload_cnt <= '0;
			clear_cnt <= '0;
			bit_cnt <= '0;
			crc <= CRC_INIT;
			crc_rx <= '0;
			clock_rate_option_o <= '0;
			half <= HALF_W'(HALF_LOWEST);
			run <= 1'b0;
			last_bit <= 1'b1;
			serial_out_o <= 1'b1; // RULE5
			init_pad_o <= '{level: 1'b0, oe_n: 1'b0};
			done_pad_o <= '{level: 1'b0, oe_n: 1'b0}; // RULE11
			cfg_write_o <= '0;
			clearing_o <= 1'b1;
			crc_error_o <= 1'b0;
			mode_error_o <= 1'b0;
			user_io_o <= 1'b0;
		end else begin
			state <= next_state;
			reload_cnt <= next_reload_cnt;
			clear_cnt <= next_clear_cnt;
			bit_cnt <= next_bit_cnt;
			crc <= next_crc;
			crc_rx <= next_crc_rx;
			clock_rate_option_o <= next_rate;
			half <= next_half;
			run <= next_run;
			last_bit <= next_last_bit;
			serial_out_o <= next_serial_out; // RULE5
			init_pad_o <= next_init_pad;
			done_pad_o <= next_done_pad;
			cfg_write_o <= next_cfg_write;
			clearing_o <= next_clearing;
			crc_error_o <= next_crc_error;
			mode_error_o <= next_mode_error;
			user_io_o <= next_user_io;
		end
	end

endmodule
